// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top import tdre_pkg::*;;
    localparam int unsigned WIN = 2000;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    tdre_cmd_t [1:0] cmd_i = '0;
    wire logic [1:0][9:0] cur_i;
    logic fault_clr_i = 1'b0;
    wire logic [1:0] enc_i;
    logic [1:0] bump_i = 2'h0;
    tdre_bridge_t [1:0] bridge_o;
    tdre_odo_t [1:0] odo_o;
    logic [1:0] blocked_o;
    logic [1:0] enc_fail_o;
    logic [1:0] bump_o;
    logic [1:0] collide_o;
    logic [1:0][15:0] half = '0;
    logic [1:0][9:0] load = '0;
    wire logic [1:0][31:0] edges;
    int mismatches = 0;
    int check_count = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    tdre_drive #(.WIN_CYCLES(WIN)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .cmd_i(cmd_i), .cur_i(cur_i), .fault_clr_i(fault_clr_i), .enc_i(enc_i),
        .bump_i(bump_i), .bridge_o(bridge_o), .odo_o(odo_o), .blocked_o(blocked_o),
        .enc_fail_o(enc_fail_o), .bump_o(bump_o), .collide_o(collide_o));
    for (genvar m = 0; m < 2; m++) begin : g_mot
        tdre_motor_model mdl (.sys_clk_i(sys_clk_i), .half_i(half[m]), .load_i(load[m]),
            .bridge_i(bridge_o[m]), .enc_o(enc_i[m]), .cur_o(cur_i[m]), .edges_o(edges[m]));
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_odo();
        chk(32'(bridge_o), 32'h0);
        @(posedge sys_clk_i);
        half[0] <= 16'h3;
        repeat (13500) @(posedge sys_clk_i);
        half[0] <= 16'h0;
        repeat (10) @(negedge sys_clk_i);
        chk(odo_o[0].seg_cnt, edges[0]);
        chk(32'(odo_o[0].rev_cnt), edges[0] / EDGES_PER_REV);
        chk(32'(odo_o[0].metre_cnt), edges[0] / SEGS_PER_METRE);
    endtask
    task automatic t_fwd();
        int w = 0;
        int p = 0;
        @(posedge sys_clk_i);
        cmd_i[0] <= '{1'b1, 1'b0, 11'h00A};
        for (int n = 0; n < 3 * WIN && !bridge_o[0].leg_a_high; n++) @(negedge sys_clk_i);
        // first pulse is cut short by the duty update, measure the next full one
        for (int n = 0; n < WIN && bridge_o[0].leg_a_high; n++) @(negedge sys_clk_i);
        for (int n = 0; n < WIN && !bridge_o[0].leg_a_high; n++) @(negedge sys_clk_i);
        while (bridge_o[0].leg_a_high && w < WIN) begin
            w++;
            @(negedge sys_clk_i);
        end
        chk(32'(bridge_o[0]), 32'h1);
        for (p = w; !bridge_o[0].leg_a_high && p < WIN; p++) @(negedge sys_clk_i);
        chk(w, 32'(DUTY_STEP));
        chk(p, 32'(PWM_PERIOD));
    endtask
    task automatic t_rev();
        int off = 0;
        @(posedge sys_clk_i);
        cmd_i[0].rev <= 1'b1;
        for (int n = 0; n < 500 && !bridge_o[0].leg_a_low; n++) begin
            if (bridge_o[0] == 4'h0) off++;
            @(negedge sys_clk_i);
        end
        chk(32'(off >= DEAD_CYC), 32'h1);
        chk(32'(bridge_o[0]), 32'h4);
    endtask
    task automatic t_clamp();
        int ons = 0;
        @(posedge sys_clk_i);
        cmd_i[0] <= '0;
        half[0] <= 16'h12;
        // let a full window of encoder edges reach the speed result before starting
        repeat (2 * WIN + 20) @(posedge sys_clk_i);
        cmd_i[0] <= '{1'b1, 1'b0, 11'h7D0};
        repeat (4 * WIN) begin
            @(negedge sys_clk_i);
            if (bridge_o[0].leg_a_high) ons++;
        end
        chk(ons, 32'h0);
        chk(32'(odo_o[0].speed >= 11'h456 && odo_o[0].speed <= 11'h460), 32'h1);
        chk(32'(bridge_o[0]), 32'h1);
    endtask
    task automatic t_block();
        @(posedge sys_clk_i);
        load[0] <= 10'h31F;
        repeat (5) @(negedge sys_clk_i);
        chk(32'(blocked_o[0]), 32'h0);
        @(posedge sys_clk_i);
        load[0] <= CUR_BLOCK_TH;
        repeat (5) @(negedge sys_clk_i);
        chk(32'(blocked_o[0]), 32'h1);
        chk(32'(bridge_o[0]), 32'h0);
        chk(32'(enc_fail_o), 32'h0);
        @(posedge sys_clk_i);
        load[0] <= 10'h000;
        cmd_i[0] <= '0;
        fault_clr_i <= 1'b1;
        @(posedge sys_clk_i);
        fault_clr_i <= 1'b0;
        repeat (3) @(negedge sys_clk_i);
        chk(32'(blocked_o[0]), 32'h0);
    endtask
    task automatic t_bump();
        int hits = 0;
        @(posedge sys_clk_i);
        bump_i[1] <= 1'b1;
        repeat (10) begin
            @(negedge sys_clk_i);
            if (collide_o[1]) hits++;
        end
        chk(hits, 32'h1);
        chk(32'(bump_o[1]), 32'h1);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(negedge sys_clk_i);
        t_odo();
        t_fwd();
        t_rev();
        t_clamp();
        t_block();
        t_bump();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        mismatches++;
        end_of_test();
    end
endmodule // tb_top
bind tdre_drive tdre_drive_props u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cmd_i(cmd_i), .cur_i(cur_i), .enc_i(enc_i), .bump_i(bump_i), .bridge_o(bridge_o),
    .odo_o(odo_o), .blocked_o(blocked_o), .collide_o(collide_o));

// ===== sim/tdre_drive_props.sv
`timescale 1ns/1ps
module tdre_drive_props import tdre_pkg::*; (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // inputs
    input tdre_cmd_t [1:0] cmd_i,
    input wire logic [1:0][9:0] cur_i,
    input wire logic [1:0] enc_i,
    input wire logic [1:0] bump_i,
    // outputs
    input tdre_bridge_t [1:0] bridge_o,
    input tdre_odo_t [1:0] odo_o,
    input wire logic [1:0] blocked_o,
    input wire logic [1:0] collide_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // consecutive cycles with all four switches of motor 0 off
    logic [6:0] off_cnt_r;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) off_cnt_r <= 7'h00;
        else if (bridge_o[0] != 4'h0) off_cnt_r <= 7'h00;
        else if (off_cnt_r != 7'h7F) off_cnt_r <= off_cnt_r + 7'h01;
    end
    chk_leg_a_excl: assert property (!(bridge_o[0].leg_a_high && bridge_o[0].leg_a_low))
        else $error("leg a shorted");
    chk_leg_b_excl: assert property (!(bridge_o[0].leg_b_high && bridge_o[0].leg_b_low))
        else $error("leg b shorted");
    chk_fwd_pair: assert property (bridge_o[0].leg_a_high |-> bridge_o[0].leg_b_low)
        else $error("forward pair broken");
    chk_dead_gap: assert property ($rose(bridge_o[0].leg_a_low) |-> off_cnt_r >= DEAD_CYC)
        else $error("dead interval too short");
    chk_seg_step: assert property ($changed(odo_o[0].seg_cnt) |->
        odo_o[0].seg_cnt == $past(odo_o[0].seg_cnt) + 32'h1) else $error("segment step");
    chk_rev_wrap: assert property ($changed(odo_o[0].rev_cnt) |->
        odo_o[0].seg_cnt % EDGES_PER_REV == 0) else $error("revolution step");
    chk_metre_wrap: assert property ($changed(odo_o[0].metre_cnt) |->
        odo_o[0].seg_cnt % SEGS_PER_METRE == 0) else $error("metre step");
    chk_block_set: assert property (cur_i[0] >= CUR_BLOCK_TH && cmd_i[0].en
        && bridge_o[0] != 4'h0 |=> blocked_o[0]) else $error("block missed");
    chk_bump_pulse: assert property ($rose(bump_i[1]) |-> ##[2:4] collide_o[1])
        else $error("collision missed");
    cover property ($rose(bridge_o[0].leg_a_low));
    cover property ($rose(blocked_o[0]));
    cover property (collide_o[1]);
endmodule // tdre_drive_props

// ===== sim/tdre_motor_model.sv
`timescale 1ns/1ps
module tdre_motor_model import tdre_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic [15:0] half_i,
    input wire logic [9:0] load_i,
    input tdre_bridge_t bridge_i,
    output logic enc_o,
    output logic [9:0] cur_o,
    output logic [31:0] edges_o
);
    logic [15:0] cnt_r = 16'h0;
    initial enc_o = 1'b0;
    initial edges_o = 32'h0;
    // encoder toggles every half_i clocks, zero holds the wheel still
    always @(posedge sys_clk_i) begin
        if (half_i == 16'h0) begin
            cnt_r <= 16'h0;
        end else if (cnt_r + 16'h1 >= half_i) begin
            cnt_r <= 16'h0;
            enc_o <= ~enc_o;
            edges_o <= edges_o + 32'h1;
        end else begin
            cnt_r <= cnt_r + 16'h1;
        end
    end
    // sense voltage develops while any bridge switch is on
    assign cur_o = (bridge_i != 4'h0) ? load_i : 10'h000;
endmodule // tdre_motor_model

// ===== verilog/tdre_drive.sv
`timescale 1ns/1ps
module tdre_drive import tdre_pkg::*; #(
    parameter int unsigned WIN_CYCLES = WIN_CYC_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // motor commands and converter results
    input tdre_cmd_t [1:0] cmd_i,
    input wire logic [1:0][9:0] cur_i,
    input wire logic fault_clr_i,
    // sensor pins
    input wire logic [1:0] enc_i,
    input wire logic [1:0] bump_i,
    // bridge drive
    output tdre_bridge_t [1:0] bridge_o,
    // odometry and status
    output tdre_odo_t [1:0] odo_o,
    output logic [1:0] blocked_o,
    output logic [1:0] enc_fail_o,
    output logic [1:0] bump_o,
    output logic [1:0] collide_o
);

    tdre_top_st_t s_r;
    tdre_top_st_t s_nxt;
    logic [1:0][10:0] tgt;
    logic [1:0] run;
    logic [1:0] pwm_on;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_odo
            tdre_odometer u_odo (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .enc_i(enc_i[gi]),
                .win_tick_i(s_r.win_tick),
                .odo_o(odo_o[gi])
            );
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        tgt = '0;
        run = '0;
        pwm_on = '0;

        // fixed timer window for speed measurement
        s_nxt.win_tick = 1'b0;
        if (s_r.win_cnt == 21'(WIN_CYCLES - 1)) begin
            s_nxt.win_cnt = '0;
            s_nxt.win_tick = 1'b1;
        end else begin
            s_nxt.win_cnt = s_r.win_cnt + 21'h00_0001;
        end

        // fixed carrier, only the compare level moves
        if (s_r.pwm_cnt == PWM_PERIOD - 10'h001) begin
            s_nxt.pwm_cnt = '0;
        end else begin
            s_nxt.pwm_cnt = s_r.pwm_cnt + 10'h001;
        end

        // bumper synchronisers and press detection
        s_nxt.bump_s1 = bump_i;
        s_nxt.bump_s2 = s_r.bump_s1;
        s_nxt.bump_prev = s_r.bump_s2;
        s_nxt.collide = s_r.bump_s2 & ~s_r.bump_prev;

        for (int m = 0; m < 2; m++) begin
            // speed target clamped into the controllable band
            tgt[m] = cmd_i[m].speed;
            if (tgt[m] > SPEED_MAX) begin
                tgt[m] = SPEED_MAX;
            end else if (tgt[m] != '0 && tgt[m] < SPEED_MIN) begin
                tgt[m] = SPEED_MIN;
            end
            run[m] = cmd_i[m].en && tgt[m] != '0 && !s_r.blocked[m];
            pwm_on[m] = s_r.pwm_cnt < s_r.duty[m];

            // blocked motor latches and forces shutdown; set beats clear
            if (cur_i[m] >= CUR_BLOCK_TH && s_r.br[m] != BR_IDLE) begin
                s_nxt.blocked[m] = 1'b1;
            end else if (fault_clr_i) begin
                s_nxt.blocked[m] = 1'b0;
            end

            // closed-loop duty step once per window
            if (!run[m] || s_r.br[m] == BR_DEAD || s_r.br[m] == BR_IDLE) begin
                s_nxt.duty[m] = '0;
            end else if (s_r.win_tick) begin
                if (odo_o[m].speed < tgt[m]) begin
                    if (s_r.duty[m] > PWM_PERIOD - DUTY_STEP) begin
                        s_nxt.duty[m] = PWM_PERIOD;
                    end else begin
                        s_nxt.duty[m] = s_r.duty[m] + DUTY_STEP;
                    end
                end else if (odo_o[m].speed > tgt[m]) begin
                    if (s_r.duty[m] < DUTY_STEP) begin
                        s_nxt.duty[m] = '0;
                    end else begin
                        s_nxt.duty[m] = s_r.duty[m] - DUTY_STEP;
                    end
                end
            end

            // full power, low current, no motion; set beats clear
            if (s_r.win_tick && s_r.duty[m] == PWM_PERIOD && cur_i[m] < CUR_LOW_TH
                    && odo_o[m].speed == '0) begin
                s_nxt.enc_fail[m] = 1'b1;
            end else if (fault_clr_i) begin
                s_nxt.enc_fail[m] = 1'b0;
            end

            // bridge sequencing
            unique case (s_r.br[m])
                BR_IDLE: begin
                    if (run[m]) begin
                        s_nxt.tgt_rev[m] = cmd_i[m].rev;
                        s_nxt.br[m] = cmd_i[m].rev ? BR_REV : BR_FWD;
                    end
                end
                BR_FWD: begin
                    if (!run[m]) begin
                        s_nxt.br[m] = BR_IDLE;
                    end else if (cmd_i[m].rev) begin
                        s_nxt.br[m] = BR_DEAD;
                        s_nxt.dead_cnt[m] = DEAD_CYC;
                    end
                end
                BR_REV: begin
                    if (!run[m]) begin
                        s_nxt.br[m] = BR_IDLE;
                    end else if (!cmd_i[m].rev) begin
                        s_nxt.br[m] = BR_DEAD;
                        s_nxt.dead_cnt[m] = DEAD_CYC;
                    end
                end
                BR_DEAD: begin
                    if (s_r.dead_cnt[m] != '0) begin
                        s_nxt.dead_cnt[m] = s_r.dead_cnt[m] - 6'h01;
                    end else if (!run[m]) begin
                        s_nxt.br[m] = BR_IDLE;
                    end else begin
                        s_nxt.tgt_rev[m] = cmd_i[m].rev;
                        s_nxt.br[m] = cmd_i[m].rev ? BR_REV : BR_FWD;
                    end
                end
            endcase

            // only one diagonal is ever selected, so no leg can short
            s_nxt.legs[m] = '0;
            if (s_r.br[m] == BR_FWD && run[m] && !cmd_i[m].rev) begin
                s_nxt.legs[m].leg_a_high = pwm_on[m];
                s_nxt.legs[m].leg_b_low = 1'b1;
            end else if (s_r.br[m] == BR_REV && run[m] && cmd_i[m].rev) begin
                s_nxt.legs[m].leg_a_low = 1'b1;
                s_nxt.legs[m].leg_b_high = pwm_on[m];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bridge_o = s_r.legs;
    assign blocked_o = s_r.blocked;
    assign enc_fail_o = s_r.enc_fail;
    assign bump_o = s_r.bump_s2;
    assign collide_o = s_r.collide;

endmodule // tdre_drive

// ===== verilog/tdre_odometer.sv
`timescale 1ns/1ps
module tdre_odometer import tdre_pkg::*; (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // encoder pin and window tick
    input wire logic enc_i,
    input wire logic win_tick_i,
    // results
    output tdre_odo_t odo_o
);

    tdre_odo_st_t s_r;
    tdre_odo_st_t s_nxt;
    logic edge_seen;
    logic [7:0] win_inc;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = enc_i;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        // both rising and falling transitions count, one segment each
        edge_seen = s_r.sync2 ^ s_r.prev;
        win_inc = s_r.win_cnt;
        if (edge_seen && s_r.win_cnt != 8'hFF) begin
            win_inc = s_r.win_cnt + 8'h01;
        end
        if (edge_seen) begin
            s_nxt.odo.seg_cnt = s_r.odo.seg_cnt + 32'h0000_0001;
            if (s_r.wheel_pos == EDGES_PER_REV - 10'h001) begin
                s_nxt.wheel_pos = '0;
                s_nxt.odo.rev_cnt = s_r.odo.rev_cnt + 16'h0001;
            end else begin
                s_nxt.wheel_pos = s_r.wheel_pos + 10'h001;
            end
            if (s_r.metre_pos == SEGS_PER_METRE - 12'h001) begin
                s_nxt.metre_pos = '0;
                s_nxt.odo.metre_cnt = s_r.odo.metre_cnt + 16'h0001;
            end else begin
                s_nxt.metre_pos = s_r.metre_pos + 12'h001;
            end
        end
        s_nxt.win_cnt = win_inc;
        if (win_tick_i) begin
            // edges in one window scaled to segments per second
            s_nxt.odo.speed = 11'(win_inc * WIN_PER_S);
            s_nxt.win_cnt = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign odo_o = s_r.odo;

endmodule // tdre_odometer

// ===== verilog/tdre_pkg.sv
package tdre_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS = 50;

    // encoder geometry
    localparam int unsigned SEG_PER_CODE_WHEEL = 36;
    localparam logic [9:0] EDGES_PER_REV = 10'h271;
    localparam logic [11:0] SEGS_PER_METRE = 12'hFA0;
    localparam int unsigned SEG_PITCH_UM = 250;

    // speed bounds in segments per second
    localparam logic [10:0] SPEED_MAX = 11'h3E8;
    localparam logic [10:0] SPEED_MECH_MAX = 11'h4B0;
    localparam logic [10:0] SPEED_MIN = 11'h032;

    // speed measurement window
    localparam int unsigned SPEED_WIN_NS = 100_000_000;
    localparam int unsigned WIN_CYC_DEF = SPEED_WIN_NS / CLK_PERIOD_NS;
    localparam logic [3:0] WIN_PER_S = 4'(1_000_000_000 / SPEED_WIN_NS);

    // pwm carrier
    localparam int unsigned PWM_FREQ_HZ = 20_000;
    localparam logic [9:0] PWM_PERIOD =
        10'(1_000_000_000 / (CLK_PERIOD_NS * PWM_FREQ_HZ));
    localparam logic [9:0] DUTY_STEP = 10'h008;

    // bridge dead interval, least time so rounded up
    localparam int unsigned DEAD_TIME_NS = 2000;
    localparam logic [5:0] DEAD_CYC =
        6'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // current thresholds in converter units
    localparam logic [9:0] CUR_BLOCK_TH = 10'h320;
    localparam logic [9:0] CUR_LOW_TH = 10'h064;

    typedef struct packed {
        logic en;
        logic rev;
        logic [10:0] speed;
    } tdre_cmd_t;

    typedef struct packed {
        logic leg_a_high;
        logic leg_a_low;
        logic leg_b_high;
        logic leg_b_low;
    } tdre_bridge_t;

    typedef struct packed {
        logic [31:0] seg_cnt;
        logic [15:0] rev_cnt;
        logic [15:0] metre_cnt;
        logic [10:0] speed;
    } tdre_odo_t;

    typedef enum logic [1:0] {
        BR_IDLE = 2'h0,
        BR_FWD  = 2'h1,
        BR_DEAD = 2'h3,
        BR_REV  = 2'h2
    } tdre_br_e;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [9:0] wheel_pos;
        logic [11:0] metre_pos;
        logic [7:0] win_cnt;
        tdre_odo_t odo;
    } tdre_odo_st_t;

    typedef struct packed {
        logic [20:0] win_cnt;
        logic win_tick;
        logic [9:0] pwm_cnt;
        logic [1:0][9:0] duty;
        tdre_br_e [1:0] br;
        logic [1:0] tgt_rev;
        logic [1:0][5:0] dead_cnt;
        logic [1:0] blocked;
        logic [1:0] enc_fail;
        logic [1:0] bump_s1;
        logic [1:0] bump_s2;
        logic [1:0] bump_prev;
        logic [1:0] collide;
        tdre_bridge_t [1:0] legs;
    } tdre_top_st_t;

endpackage
